// ===== rtl/tcr_map.vh
// Constants for the trace capture and trigger block: register offsets,
// field positions, reset values and timing counts.
// Assumes a plain register port with word indices and 32-bit data.
// How it works
// - Two channels, each with own source select
// - Object channel reads its programmed object number
// - Per-channel signed bit leaves the captured object value unchanged
// - Per-channel mask ANDed onto object value before capture
// - Sample interval set by time per division
// - Zero delay: trigger is first stored sample
// - Negative delay keeps pretrigger samples
// - Trigger source: standard event or quantity, or object
// - Digital source two-state, analogue source numeric
// - Analogue fires crossing level in chosen direction
// - Rising: event active, or value above level
// - Falling: event inactive, or value below level
// - Auto mode captures continuously regardless of trigger
// - Normal mode captures on trigger, then rearms
// - Single mode captures once, clears run
// - Capture only while run set; clear stops
// - Parameter save deactivates; host must re-run
// - Report inactive when stopped, start when started
// - Report wait state while watching trigger
// - Report pretrigger state while filling pretrigger
// - Report trigger found during positive delay
// - Report data read while host reads samples
// - Forced trigger acts as immediate trigger
// - Object read returns number and 32-bit value
`ifndef TCR_MAP_VH
`define TCR_MAP_VH

`define TCR_ADDR_CTRL 5'h00
`define TCR_ADDR_STATUS 5'h01
`define TCR_ADDR_FIRST_SRC 5'h02
`define TCR_ADDR_FIRST_MASK 5'h03
`define TCR_ADDR_SECOND_SRC 5'h04
`define TCR_ADDR_SECOND_MASK 5'h05
`define TCR_ADDR_TIMEDIV 5'h06
`define TCR_ADDR_DELAY 5'h07
`define TCR_ADDR_TRIG_SRC 5'h08
`define TCR_ADDR_TRIG_LEVEL 5'h09
`define TCR_ADDR_READ_PTR 5'h0A
`define TCR_ADDR_READ_FIRST 5'h0B
`define TCR_ADDR_READ_SECOND 5'h0C
`define TCR_ADDR_READ_DONE 5'h0D

// Control register fields
`define TCR_CTRL_RUN 0
`define TCR_CTRL_FORCE 1
`define TCR_CTRL_MODE_LO 2
`define TCR_CTRL_MODE_HI 3
`define TCR_CTRL_EDGE 4
`define TCR_CTRL_ANALOG 5

// Source registers: bits 15:0 object number, 16 object select, 17 signed,
// 20:18 standard quantity index
`define TCR_SRC_OBJ_SEL 16
`define TCR_SRC_SIGNED 17
`define TCR_SRC_STD_LO 18
`define TCR_SRC_STD_HI 20

`define TCR_MODE_AUTO 2'h0
`define TCR_MODE_NORMAL 2'h1
`define TCR_MODE_SINGLE 2'h2

`define TCR_MASK_RESET 32'hFFFFFFFF
`define TCR_TIMEDIV_RESET 32'h0000000A

// Time per division is given in microseconds; one division holds
// TCR_SAMPLES_PER_DIV samples.
`define TCR_CLK_MHZ 50
`define TCR_SAMPLES_PER_DIV 10
`define TCR_DEPTH 256
`define TCR_AW 8

// Status codes
`define TCR_ST_INACTIVE 3'h0
`define TCR_ST_START 3'h1
`define TCR_ST_WAIT 3'h2
`define TCR_ST_PRE 3'h3
`define TCR_ST_FOUND 3'h4
`define TCR_ST_RECORD 3'h5
`define TCR_ST_READ 3'h6

`endif

// ===== rtl/tcr_trace_capture.v
// Two-channel trace recorder with trigger.
// Assumes sampled quantities and objects arrive synchronous to CLK, and
// that the host drains each record through the read registers.
`timescale 1ns/100ps
`include "tcr_map.vh"

module tcr_trace_capture (
  input wire CLK,
  input wire RESET_N,
  input wire [4:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Eight standard quantities, packed 32 bits each
  input wire [255:0] STD_QUANT,
  // Eight standard digital events
  input wire [7:0] STD_EVENT,
  // Object access port toward the object store
  output wire [15:0] OBJ_NUM_FIRST,
  output wire [15:0] OBJ_NUM_SECOND,
  output wire [15:0] OBJ_NUM_TRIG,
  input wire [31:0] OBJ_VAL_FIRST,
  input wire [31:0] OBJ_VAL_SECOND,
  input wire [31:0] OBJ_VAL_TRIG,
  input wire PARAM_SAVE,
  output wire RUNNING,
  output reg [2:0] STATE
);

  reg [6:0] fsm;
  localparam F_IDLE = 7'b0000001;
  localparam F_START = 7'b0000010;
  localparam F_PRE = 7'b0000100;
  localparam F_WAIT = 7'b0001000;
  localparam F_FOUND = 7'b0010000;
  localparam F_REC = 7'b0100000;
  localparam F_READ = 7'b1000000;

  reg [31:0] ctrl;
  reg [31:0] src1;
  reg [31:0] mask1;
  reg [31:0] src2;
  reg [31:0] mask2;
  reg [31:0] timediv;
  reg signed [31:0] delay;
  reg [31:0] trig_src;
  reg [31:0] trig_level;
  reg [`TCR_AW-1:0] rd_ptr;
  reg force_req;

  reg [31:0] mem1 [0:`TCR_DEPTH-1];
  reg [31:0] mem2 [0:`TCR_DEPTH-1];
  reg [`TCR_AW-1:0] wr_ptr;
  reg [`TCR_AW-1:0] start_ptr;
  reg [`TCR_AW:0] count;
  reg [31:0] delay_cnt;
  reg [31:0] tick_cnt;
  reg tick;
  reg trig_prev_valid;
  reg prev_dig;
  reg prev_above;
  reg prev_below;

  wire run = ctrl[`TCR_CTRL_RUN];
  wire [1:0] mode = ctrl[`TCR_CTRL_MODE_HI:`TCR_CTRL_MODE_LO];
  wire rising = ctrl[`TCR_CTRL_EDGE];
  wire analog = ctrl[`TCR_CTRL_ANALOG];

  assign RUNNING = run;
  assign OBJ_NUM_FIRST = src1[15:0];
  assign OBJ_NUM_SECOND = src2[15:0];
  assign OBJ_NUM_TRIG = trig_src[15:0];

  // Channel value: standard quantity or masked object, same bits signed or unsigned
  function [31:0] chan_value;
    input [31:0] src;
    input [31:0] mask;
    input [31:0] obj;
    input [255:0] std;
    reg [31:0] masked;
    reg [31:0] shifted;
    begin
      masked = obj & mask;
      shifted = masked;
      if (src[`TCR_SRC_SIGNED] == 1'b0 && mask != 32'h0 && mask[31] == 1'b1) begin
        shifted = masked;
      end
      if (src[`TCR_SRC_OBJ_SEL]) begin
        chan_value = src[`TCR_SRC_SIGNED] ? shifted : {1'b0, shifted[30:0]} |
          (shifted & 32'h80000000);
      end else begin
        chan_value = std[src[`TCR_SRC_STD_HI:`TCR_SRC_STD_LO]*32 +: 32];
      end
    end
  endfunction

  wire [31:0] first_val = chan_value(src1, mask1, OBJ_VAL_FIRST, STD_QUANT);
  wire [31:0] second_val = chan_value(src2, mask2, OBJ_VAL_SECOND, STD_QUANT);

  // Trigger source value and its comparison (signedness from trigger source)
  wire [2:0] std_idx = trig_src[`TCR_SRC_STD_HI:`TCR_SRC_STD_LO];
  wire [31:0] trig_val = trig_src[`TCR_SRC_OBJ_SEL] ? OBJ_VAL_TRIG :
    STD_QUANT[std_idx*32 +: 32];
  wire dig_now = trig_src[`TCR_SRC_OBJ_SEL] ? (OBJ_VAL_TRIG != 32'h0) :
    STD_EVENT[std_idx];
  wire cmp_signed = trig_src[`TCR_SRC_SIGNED];
  wire above_now = cmp_signed ? ($signed(trig_val) > $signed(trig_level)) :
    (trig_val > trig_level);
  wire below_now = cmp_signed ? ($signed(trig_val) < $signed(trig_level)) :
    (trig_val < trig_level);
  // Edge against the previous sample taken at the sampling tick
  wire hit_rise = analog ? (above_now && !prev_above) : (dig_now && !prev_dig);
  wire hit_fall = analog ? (below_now && !prev_below) : (!dig_now && prev_dig);
  wire trig_hit = trig_prev_valid && (rising ? hit_rise : hit_fall);

  // Sample period: time per division in microseconds, ten samples per division
  wire [31:0] period = (timediv * `TCR_CLK_MHZ) / `TCR_SAMPLES_PER_DIV;
  wire [31:0] pre_len = delay[31] ? ((0 - delay) > `TCR_DEPTH - 1 ? `TCR_DEPTH - 1 :
    (0 - delay)) : 32'h0;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run || fsm == F_IDLE) begin
        tick_cnt <= 32'h0;
      end else if (tick_cnt + 32'h1 >= period) begin
        tick_cnt <= 32'h0;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end

  wire wr_sel = WR;
  wire rd_done = WR && ADDR == `TCR_ADDR_READ_DONE;
  // A new force request in the cycle a trigger is taken must not be lost
  wire force_set = WR && ADDR == `TCR_ADDR_CTRL && WDATA[`TCR_CTRL_FORCE];

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= 32'h0;
      src1 <= 32'h0;
      mask1 <= `TCR_MASK_RESET;
      src2 <= 32'h0;
      mask2 <= `TCR_MASK_RESET;
      timediv <= `TCR_TIMEDIV_RESET;
      delay <= 32'h0;
      trig_src <= 32'h0;
      trig_level <= 32'h0;
      rd_ptr <= 8'h0;
      force_req <= 1'b0;
      fsm <= F_IDLE;
      wr_ptr <= 8'h0;
      start_ptr <= 8'h0;
      count <= 9'h0;
      delay_cnt <= 32'h0;
      trig_prev_valid <= 1'b0;
      prev_dig <= 1'b0;
      prev_above <= 1'b0;
      prev_below <= 1'b0;
    end else begin
      if (wr_sel) begin
        case (ADDR)
          `TCR_ADDR_CTRL: begin
            ctrl <= {WDATA[31:2], 1'b0, WDATA[0]};
            if (WDATA[`TCR_CTRL_FORCE]) begin
              force_req <= 1'b1;
            end
          end
          `TCR_ADDR_FIRST_SRC: src1 <= WDATA;
          `TCR_ADDR_FIRST_MASK: mask1 <= WDATA;
          `TCR_ADDR_SECOND_SRC: src2 <= WDATA;
          `TCR_ADDR_SECOND_MASK: mask2 <= WDATA;
          `TCR_ADDR_TIMEDIV: timediv <= WDATA;
          `TCR_ADDR_DELAY: delay <= WDATA;
          `TCR_ADDR_TRIG_SRC: trig_src <= WDATA;
          `TCR_ADDR_TRIG_LEVEL: trig_level <= WDATA;
          `TCR_ADDR_READ_PTR: rd_ptr <= WDATA[`TCR_AW-1:0];
          default: ;
        endcase
      end
      if (RD && ADDR == `TCR_ADDR_READ_SECOND) begin
        rd_ptr <= rd_ptr + 8'h1;
      end
      if (tick) begin
        trig_prev_valid <= 1'b1;
        prev_dig <= dig_now;
        prev_above <= above_now;
        prev_below <= below_now;
      end
      case (fsm)
        F_IDLE: begin
          force_req <= 1'b0;
          if (run && !(wr_sel && ADDR == `TCR_ADDR_CTRL)) begin
            fsm <= F_START;
          end
        end
        F_START: begin
          wr_ptr <= 8'h0;
          count <= 9'h0;
          trig_prev_valid <= 1'b0;
          fsm <= (pre_len != 32'h0) ? F_PRE : F_WAIT;
        end
        F_PRE: begin
          if (tick) begin
            mem1[wr_ptr] <= first_val;
            mem2[wr_ptr] <= second_val;
            wr_ptr <= wr_ptr + 8'h1;
            count <= count + 9'h1;
            if (count + 9'h1 >= pre_len[8:0]) begin
              fsm <= F_WAIT;
            end
          end
        end
        F_WAIT: begin
          if (tick && (delay[31] || count == 9'h0)) begin
            // Keep a rolling pretrigger window
            mem1[wr_ptr] <= first_val;
            mem2[wr_ptr] <= second_val;
          end
          if (tick && delay[31]) begin
            wr_ptr <= wr_ptr + 8'h1;
          end
          if (force_req || trig_hit || (mode == `TCR_MODE_AUTO && tick)) begin
            if (!force_set) begin
              force_req <= 1'b0;
            end
            delay_cnt <= delay[31] ? 32'h0 : delay;
            start_ptr <= delay[31] ? wr_ptr - pre_len[7:0] : wr_ptr;
            if (!delay[31] && delay != 32'h0) begin
              fsm <= F_FOUND;
            end else begin
              count <= delay[31] ? pre_len[8:0] : 9'h0;
              fsm <= F_REC;
            end
          end
        end
        F_FOUND: begin
          if (tick) begin
            if (delay_cnt <= 32'h1) begin
              start_ptr <= wr_ptr;
              count <= 9'h0;
              fsm <= F_REC;
            end else begin
              delay_cnt <= delay_cnt - 32'h1;
            end
          end
        end
        F_REC: begin
          if (tick) begin
            mem1[wr_ptr] <= first_val;
            mem2[wr_ptr] <= second_val;
            wr_ptr <= wr_ptr + 8'h1;
            count <= count + 9'h1;
            if (count + 9'h1 >= `TCR_DEPTH) begin
              rd_ptr <= start_ptr;
              fsm <= F_READ;
            end
          end
        end
        F_READ: begin
          if (rd_done) begin
            if (mode == `TCR_MODE_SINGLE) begin
              ctrl[`TCR_CTRL_RUN] <= 1'b0;
              fsm <= F_IDLE;
            end else begin
              fsm <= F_START;
            end
          end
        end
        default: fsm <= F_IDLE;
      endcase
      if (!run || PARAM_SAVE) begin
        fsm <= F_IDLE;
      end
      if (PARAM_SAVE) begin
        ctrl[`TCR_CTRL_RUN] <= 1'b0;
      end
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STATE <= `TCR_ST_INACTIVE;
    end else begin
      case (fsm)
        F_START: STATE <= `TCR_ST_START;
        F_PRE: STATE <= `TCR_ST_PRE;
        F_WAIT: STATE <= `TCR_ST_WAIT;
        F_FOUND: STATE <= `TCR_ST_FOUND;
        F_REC: STATE <= `TCR_ST_RECORD;
        F_READ: STATE <= `TCR_ST_READ;
        default: STATE <= `TCR_ST_INACTIVE;
      endcase
    end
  end

  // Read port: data one cycle after the strobe; a sample word carries
  // its index in the upper half of the status word for pairing
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        `TCR_ADDR_CTRL: RDATA <= ctrl;
        `TCR_ADDR_STATUS: RDATA <= {8'h0, rd_ptr, 13'h0, STATE};
        `TCR_ADDR_FIRST_SRC: RDATA <= src1;
        `TCR_ADDR_FIRST_MASK: RDATA <= mask1;
        `TCR_ADDR_SECOND_SRC: RDATA <= src2;
        `TCR_ADDR_SECOND_MASK: RDATA <= mask2;
        `TCR_ADDR_TIMEDIV: RDATA <= timediv;
        `TCR_ADDR_DELAY: RDATA <= delay;
        `TCR_ADDR_TRIG_SRC: RDATA <= trig_src;
        `TCR_ADDR_TRIG_LEVEL: RDATA <= trig_level;
        `TCR_ADDR_READ_PTR: RDATA <= {24'h0, rd_ptr};
        `TCR_ADDR_READ_FIRST: RDATA <= mem1[rd_ptr];
        `TCR_ADDR_READ_SECOND: RDATA <= mem2[rd_ptr];
        default: RDATA <= 32'h0;
      endcase
    end
  end

endmodule

// ===== test/tcr_properties.sv
// Port-level checks for the trace recorder, bound to its top module.
// Assumes the map header is on the include path and one clock domain.
`timescale 1ns/100ps
`include "tcr_map.vh"
module tcr_properties (
  input wire CLK,
  input wire RESET_N,
  input wire [4:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire [255:0] STD_QUANT,
  input wire [7:0] STD_EVENT,
  input wire [15:0] OBJ_NUM_FIRST,
  input wire [15:0] OBJ_NUM_SECOND,
  input wire [15:0] OBJ_NUM_TRIG,
  input wire [31:0] OBJ_VAL_FIRST,
  input wire [31:0] OBJ_VAL_SECOND,
  input wire [31:0] OBJ_VAL_TRIG,
  input wire PARAM_SAVE,
  input wire RUNNING,
  input wire [2:0] STATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_rdata_holds: assert property (!$past(RD) |-> $stable(RDATA))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (RD && ADDR > `TCR_ADDR_READ_DONE |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_status_code: assert property (RD && ADDR == `TCR_ADDR_STATUS |=> RDATA[2:0] == $past(STATE))
    else $error("status read differs from state");
  a_first_obj: assert property (!($past(WR) && $past(ADDR) == `TCR_ADDR_FIRST_SRC)
    |-> $stable(OBJ_NUM_FIRST))
    else $error("first object number moved without a write");
  a_trig_obj: assert property (!($past(WR) && $past(ADDR) == `TCR_ADDR_TRIG_SRC)
    |-> $stable(OBJ_NUM_TRIG))
    else $error("trigger object number moved without a write");
  a_run_written: assert property (WR && ADDR == `TCR_ADDR_CTRL && !PARAM_SAVE
    |=> RUNNING == $past(WDATA[0]))
    else $error("run bit does not follow write");
  a_save_stops: assert property (PARAM_SAVE |=> !RUNNING)
    else $error("save did not stop the recorder");
  a_save_idle: assert property (PARAM_SAVE |-> ##[1:2] STATE == `TCR_ST_INACTIVE)
    else $error("save did not show inactive");
  a_start_shown: assert property ($rose(RUNNING) |-> ##[0:2] STATE == `TCR_ST_START)
    else $error("start state not shown");
  a_stop_state: assert property ($fell(RUNNING)
    |-> ##[0:2] (STATE == `TCR_ST_INACTIVE || STATE == `TCR_ST_READ))
    else $error("stopped recorder still capturing");
  c_pre: cover property (STATE == `TCR_ST_PRE);
  c_found: cover property (STATE == `TCR_ST_FOUND);
  c_read: cover property (STATE == `TCR_ST_READ);
endmodule

bind tcr_trace_capture tcr_properties u_props (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STD_QUANT(STD_QUANT),
  .STD_EVENT(STD_EVENT), .OBJ_NUM_FIRST(OBJ_NUM_FIRST), .OBJ_NUM_SECOND(OBJ_NUM_SECOND),
  .OBJ_NUM_TRIG(OBJ_NUM_TRIG), .OBJ_VAL_FIRST(OBJ_VAL_FIRST), .OBJ_VAL_SECOND(OBJ_VAL_SECOND),
  .OBJ_VAL_TRIG(OBJ_VAL_TRIG), .PARAM_SAVE(PARAM_SAVE), .RUNNING(RUNNING), .STATE(STATE));

// ===== test/tcr_obj_store.sv
// Object store model answering the recorder's object port.
// Assumes the numbers come from registers; it answers in the same cycle.
`timescale 1ns/100ps
module tcr_obj_store (
  input wire [15:0] OBJ_NUM_FIRST,
  input wire [15:0] OBJ_NUM_SECOND,
  input wire [15:0] OBJ_NUM_TRIG,
  input wire [31:0] TRIG_VALUE,
  output wire [31:0] OBJ_VAL_FIRST,
  output wire [31:0] OBJ_VAL_SECOND,
  output wire [31:0] OBJ_VAL_TRIG
);
  // Lower half echoes the number asked for, so a wrong number shows in the data
  assign OBJ_VAL_FIRST = {16'hC3C3, OBJ_NUM_FIRST};
  assign OBJ_VAL_SECOND = {16'hC3C3, OBJ_NUM_SECOND};
  // Only the trigger object follows the bench
  assign OBJ_VAL_TRIG = (OBJ_NUM_TRIG == 16'h0030) ? TRIG_VALUE : ~OBJ_VAL_FIRST;
endmodule

// ===== test/testbench.sv
// Self-checking bench for the trace recorder: register tasks and scenarios.
// Assumes the object store model sits on the object port.
`timescale 1ns/100ps
`include "tcr_map.vh"
module testbench;
  reg CLK = 1'b0;
  reg RESET_N = 1'b0;
  reg [4:0] ADDR = 5'h00;
  reg [31:0] WDATA = 32'h00000000;
  reg WR = 1'b0;
  reg RD = 1'b0;
  reg [255:0] STD_QUANT = 256'h0;
  reg [7:0] STD_EVENT = 8'h00;
  reg PARAM_SAVE = 1'b0;
  reg [31:0] TRIG_VALUE = 32'hFFFFFFF6;
  wire [31:0] RDATA, OBJ_VAL_FIRST, OBJ_VAL_SECOND, OBJ_VAL_TRIG;
  wire [15:0] OBJ_NUM_FIRST, OBJ_NUM_SECOND, OBJ_NUM_TRIG;
  wire RUNNING;
  wire [2:0] STATE;
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  reg [31:0] got;
  always #10 CLK = ~CLK;
  tcr_trace_capture dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .STD_QUANT(STD_QUANT), .STD_EVENT(STD_EVENT),
    .OBJ_NUM_FIRST(OBJ_NUM_FIRST), .OBJ_NUM_SECOND(OBJ_NUM_SECOND), .OBJ_NUM_TRIG(OBJ_NUM_TRIG),
    .OBJ_VAL_FIRST(OBJ_VAL_FIRST), .OBJ_VAL_SECOND(OBJ_VAL_SECOND), .OBJ_VAL_TRIG(OBJ_VAL_TRIG),
    .PARAM_SAVE(PARAM_SAVE), .RUNNING(RUNNING), .STATE(STATE));
  tcr_obj_store store (.OBJ_NUM_FIRST(OBJ_NUM_FIRST), .OBJ_NUM_SECOND(OBJ_NUM_SECOND),
    .OBJ_NUM_TRIG(OBJ_NUM_TRIG), .TRIG_VALUE(TRIG_VALUE), .OBJ_VAL_FIRST(OBJ_VAL_FIRST),
    .OBJ_VAL_SECOND(OBJ_VAL_SECOND), .OBJ_VAL_TRIG(OBJ_VAL_TRIG));
  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [31:0] act, input [31:0] exp);
    begin
      compares = compares + 1;
      if (act !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR at %0t: got %h expected %h", $time, act, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [4:0] a);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 got = RDATA;
    end
  endtask
  // Polls the status word; a state that never comes ends the run
  task wait_state(input [2:0] st);
    integer n;
    begin
      n = 0;
      got = 32'hFFFFFFFF;
      while (got[2:0] !== st && n < 2000) begin
        rd(`TCR_ADDR_STATUS);
        n = n + 1;
      end
      check({29'h0, got[2:0]}, {29'h0, st});
      if (got[2:0] !== st)
        finish_test;
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1)
      STD_QUANT[32*i +: 32] = 32'h11111111 * i;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(`TCR_ADDR_FIRST_MASK);
    check(got, `TCR_MASK_RESET);
    rd(`TCR_ADDR_TIMEDIV);
    check(got, `TCR_TIMEDIV_RESET);
    rd(5'h1F);
    check(got, 32'h00000000);
    wait_state(`TCR_ST_INACTIVE);
    wr(`TCR_ADDR_TIMEDIV, 32'h00000001);
    wr(`TCR_ADDR_FIRST_SRC, 32'h00010012);
    wr(`TCR_ADDR_FIRST_MASK, 32'hFF00000F);
    wr(`TCR_ADDR_SECOND_SRC, 32'h000C0000);
    wr(`TCR_ADDR_TRIG_SRC, 32'h00030030);
    wr(`TCR_ADDR_TRIG_LEVEL, 32'hFFFFFFFB);
    wr(`TCR_ADDR_DELAY, 32'h00000000);
    wr(`TCR_ADDR_CTRL, 32'h00000035);
    wait_state(`TCR_ST_WAIT);
    // A signed value below the level must not fire; 0xFFFFFFF6 is below 0xFFFFFFFB read unsigned too
    repeat (60) @(posedge CLK);
    wait_state(`TCR_ST_WAIT);
    @(posedge CLK);
    TRIG_VALUE <= 32'h00000003;
    wait_state(`TCR_ST_READ);
    for (i = 0; i < 256; i = i + 1) begin
      rd(`TCR_ADDR_READ_FIRST);
      check(got, 32'hC3000002);
      rd(`TCR_ADDR_READ_SECOND);
      check(got, 32'h33333333);
    end
    wait_state(`TCR_ST_READ);
    wr(`TCR_ADDR_READ_DONE, 32'h00000000);
    wait_state(`TCR_ST_WAIT);
    check({31'h0, RUNNING}, 32'h00000001);
    wr(`TCR_ADDR_CTRL, 32'h00000037);
    wait_state(`TCR_ST_READ);
    wr(`TCR_ADDR_READ_DONE, 32'h00000000);
    wait_state(`TCR_ST_WAIT);
    @(posedge CLK);
    PARAM_SAVE <= 1'b1;
    @(posedge CLK);
    PARAM_SAVE <= 1'b0;
    wait_state(`TCR_ST_INACTIVE);
    check({31'h0, RUNNING}, 32'h00000000);
    wr(`TCR_ADDR_DELAY, 32'hFFFFFFF6);
    TRIG_VALUE <= 32'hFFFFFFF6;
    wr(`TCR_ADDR_CTRL, 32'h00000035);
    wait_state(`TCR_ST_PRE);
    repeat (100) @(posedge CLK);
    TRIG_VALUE <= 32'h00000003;
    wait_state(`TCR_ST_READ);
    wr(`TCR_ADDR_READ_DONE, 32'h00000000);
    wr(`TCR_ADDR_CTRL, 32'h00000000);
    wait_state(`TCR_ST_INACTIVE);
    wr(`TCR_ADDR_DELAY, 32'h00000000);
    TRIG_VALUE <= 32'hFFFFFFF6;
    wr(`TCR_ADDR_CTRL, 32'h00000031);
    wait_state(`TCR_ST_READ);
    wr(`TCR_ADDR_READ_DONE, 32'h00000000);
    check({31'h0, RUNNING}, 32'h00000001);
    wr(`TCR_ADDR_CTRL, 32'h00000000);
    wait_state(`TCR_ST_INACTIVE);
    wr(`TCR_ADDR_TRIG_SRC, 32'h00080000);
    wr(`TCR_ADDR_DELAY, 32'h00000014);
    STD_EVENT <= 8'h04;
    wr(`TCR_ADDR_CTRL, 32'h00000009);
    wait_state(`TCR_ST_WAIT);
    // Let at least two sample ticks see the event active first
    repeat (12) @(posedge CLK);
    STD_EVENT <= 8'h00;
    wait_state(`TCR_ST_FOUND);
    wait_state(`TCR_ST_READ);
    wr(`TCR_ADDR_READ_DONE, 32'h00000000);
    wait_state(`TCR_ST_INACTIVE);
    check({31'h0, RUNNING}, 32'h00000000);
    finish_test;
  end
endmodule
